/* hw/slm_rx.sv */
`include "slm_cfg.svh"

module slm_rx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] link_layout_select,
  slm_link_if.rx link,
  output logic out_valid,
  output slm_pkg::slm_chans_t out_samples,
  output logic tail_err,
  output logic lane_err
);

  // Samples narrower than 12 bits come out right justified with zero above.
  function automatic slm_pkg::slm_chans_t unpack_frame(input logic [3:0] mode, input slm_pkg::slm_lanes_t ln);
    slm_pkg::slm_chans_t ch;
    logic [95:0] cat;
    ch = '0;
    cat = '0;
    case (slm_pkg::slm_mode_t'(mode))
      slm_pkg::SLM_M0: begin
        for (int c = 0; c < 4; c++) begin
          for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 5; k++) begin
              ch[c][p+2*k] = ln[2*c+p][63-12*k -: 12];
            end
          end
        end
      end
      slm_pkg::SLM_M1, slm_pkg::SLM_M6, slm_pkg::SLM_M4: begin
        for (int l = 0; l < 6; l++) begin
          cat[95-16*l -: 16] = ln[l][63 -: 16];
        end
        if (mode == `SLM_MODE_4) begin
          for (int c = 0; c < 4; c++) begin
            ch[c][0] = cat[95-12*c -: 12];
          end
        end else begin
          for (int c = 0; c < 4; c++) begin
            ch[c][0] = cat[95-24*c -: 12];
            ch[c][1] = cat[83-24*c -: 12];
          end
        end
      end
      slm_pkg::SLM_M2, slm_pkg::SLM_M7: begin
        for (int c = 0; c < 4; c++) begin
          ch[c][0] = {4'h0, ln[c][63 -: 8]};
        end
      end
      slm_pkg::SLM_M3: begin
        for (int c = 0; c < 4; c++) begin
          for (int k = 0; k < 4; k++) begin
            ch[c][k] = {2'h0, ln[c][63-10*k -: 10]};
          end
        end
      end
      slm_pkg::SLM_M5: begin
        ch[0][0] = {4'h0, ln[0][63:56]};
        ch[1][0] = {4'h0, ln[0][55:48]};
        ch[2][0] = {4'h0, ln[1][63:56]};
        ch[3][0] = {4'h0, ln[1][55:48]};
      end
      default: ch = '0;
    endcase
    return ch;
  endfunction

  slm_pkg::slm_lanes_t acc_ff;
  slm_pkg::slm_lanes_t nxt_acc;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [3:0] idx;
  logic done;
  logic out_valid_ff;
  logic nxt_out_valid;
  slm_pkg::slm_chans_t samples_ff;
  slm_pkg::slm_chans_t nxt_samples;
  logic tail_err_ff;
  logic nxt_tail_err;
  logic lane_err_ff;
  logic nxt_lane_err;

  always_comb begin
    nxt_acc = acc_ff;
    nxt_cnt = cnt_ff;
    nxt_samples = samples_ff;
    nxt_out_valid = 1'b0;
    nxt_tail_err = 1'b0;
    idx = link.frame_start ? 4'h0 : cnt_ff;
    done = link.oct_valid && (idx == slm_pkg::oct_per_frame(link_layout_select) - 4'h1);
    if (link.oct_valid) begin
      if (link.frame_start) begin
        nxt_acc = '0;
      end
      for (int l = 0; l < 8; l++) begin
        nxt_acc[l][8*(7-idx) +: 8] = link.lane[l];
      end
      nxt_cnt = idx + 4'h1;
    end
    if (done) begin
      nxt_samples = unpack_frame(link_layout_select, nxt_acc);
      nxt_out_valid = 1'b1;
      if (link_layout_select == `SLM_MODE_0) begin
        for (int l = 0; l < 8; l++) begin
          nxt_tail_err = nxt_tail_err | (nxt_acc[l][3:0] != 4'h0);
        end
      end
    end
    // The far end must light exactly the low lanes that this layout expects.
    nxt_lane_err = (link.lane_on != slm_pkg::lane_mask(link_layout_select));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= '0;
      cnt_ff <= 4'h0;
      samples_ff <= '0;
      out_valid_ff <= 1'b0;
      tail_err_ff <= 1'b0;
      lane_err_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
      samples_ff <= nxt_samples;
      out_valid_ff <= nxt_out_valid;
      tail_err_ff <= nxt_tail_err;
      lane_err_ff <= nxt_lane_err;
    end
  end

  assign out_valid = out_valid_ff;
  assign out_samples = samples_ff;
  assign tail_err = tail_err_ff;
  assign lane_err = lane_err_ff;

endmodule // slm_rx

/* hw/slm_tx.sv */
// Behaviour
// - Mode 0: channels A to D, two lanes each, five samples plus tail.
// - Mode 1: eight samples concatenated, 16-bit lane slices.
// - Mode 6 packs exactly like mode 1.
// - Mode 2: one octet per lane, A to D.
// - Mode 7 uses the mode 2 layout.
// - Mode 3: four 10-bit samples per lane.
// - Mode 4: A0..D0 concatenated, three 16-bit slices.
// - Mode 5: lane 0 A,B; lane 1 C,D.
// - Tail bits zero, samples MSB first.
// - Lowest lanes used, higher lanes powered down.
// - One select picks a mode; others refused.
`include "slm_cfg.svh"

module slm_tx (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] link_layout_select,
  input wire logic frm_valid,
  output logic frm_ready,
  input wire slm_pkg::slm_chans_t frm_samples,
  slm_link_if.tx link
);

  typedef enum logic [0:0] {
    SLM_TX_IDLE = 1'b0,
    SLM_TX_SEND = 1'b1
  } slm_tx_state_t;

  // Modes 1, 4 and 6 cut one long word into 16-bit lane pieces, lane 0 first.
  function automatic logic [15:0] slice16(input logic [95:0] cat, input int l);
    slice16 = cat[95-16*l -: 16];
  endfunction

  // Every lane moves up one octet and zero fills in from below, so lanes read zero after a frame.
  function automatic slm_pkg::slm_lanes_t shift_up(input slm_pkg::slm_lanes_t ln);
    slm_pkg::slm_lanes_t r;
    r = '0;
    for (int l = 0; l < 8; l++) begin
      r[l] = {ln[l][55:0], 8'h00};
    end
    return r;
  endfunction

  // Unused sample slots stay zero in the lane frame, so tails and idle lanes read zero.
  function automatic slm_pkg::slm_lanes_t pack_frame(input logic [3:0] mode, input slm_pkg::slm_chans_t ch);
    slm_pkg::slm_lanes_t ln;
    logic [95:0] cat;
    ln = '0;
    cat = '0;
    case (slm_pkg::slm_mode_t'(mode))
      slm_pkg::SLM_M0: begin
        // Even samples go on the even lane and odd samples on the odd lane, five 12-bit slots each.
        for (int c = 0; c < 4; c++) begin
          for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 5; k++) begin
              ln[2*c+p][63-12*k -: 12] = ch[c][p+2*k];
            end
          end
        end
      end
      slm_pkg::SLM_M1, slm_pkg::SLM_M6: begin
        cat = {ch[0][0], ch[0][1], ch[1][0], ch[1][1], ch[2][0], ch[2][1], ch[3][0], ch[3][1]};
        ln[0][63 -: 16] = slice16(cat, 0);
        ln[1][63 -: 16] = slice16(cat, 1);
        ln[2][63 -: 16] = slice16(cat, 2);
        ln[3][63 -: 16] = slice16(cat, 3);
        ln[4][63 -: 16] = slice16(cat, 4);
        ln[5][63 -: 16] = slice16(cat, 5);
      end
      slm_pkg::SLM_M2, slm_pkg::SLM_M7: begin
        for (int c = 0; c < 4; c++) begin
          ln[c][63 -: 8] = ch[c][0][7:0];
        end
      end
      slm_pkg::SLM_M3: begin
        for (int c = 0; c < 4; c++) begin
          for (int k = 0; k < 4; k++) begin
            ln[c][63-10*k -: 10] = ch[c][k][9:0];
          end
        end
      end
      slm_pkg::SLM_M4: begin
        cat[95:48] = {ch[0][0], ch[1][0], ch[2][0], ch[3][0]};
        ln[0][63 -: 16] = slice16(cat, 0);
        ln[1][63 -: 16] = slice16(cat, 1);
        ln[2][63 -: 16] = slice16(cat, 2);
      end
      slm_pkg::SLM_M5: begin
        ln[0][63 -: 16] = {ch[0][0][7:0], ch[1][0][7:0]};
        ln[1][63 -: 16] = {ch[2][0][7:0], ch[3][0][7:0]};
      end
      default: ln = '0;
    endcase
    return ln;
  endfunction

  slm_tx_state_t state_ff;
  slm_tx_state_t nxt_state;
  slm_pkg::slm_lanes_t shift_ff;
  slm_pkg::slm_lanes_t nxt_shift;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [3:0] mode_ff;
  logic [3:0] nxt_mode;
  logic [7:0] lane_on_ff;
  logic [7:0] nxt_lane_on;
  logic last_oct;
  logic take;
  logic in_frame;
  logic first_oct;

  // The layout of a frame in flight is held in mode_ff, so a select change
  // reaches frame length and packing only at the next accepted frame.
  always_comb begin
    in_frame = (state_ff == SLM_TX_SEND);
    first_oct = in_frame && (cnt_ff == 4'h0);
    last_oct = in_frame && (cnt_ff == slm_pkg::oct_per_frame(mode_ff) - 4'h1);
    // An unsupported select holds ready low, so no frame is ever taken in it.
    frm_ready = slm_pkg::mode_ok(link_layout_select) && ((state_ff == SLM_TX_IDLE) || last_oct);
    take = frm_valid && frm_ready;
  end

  // Frame control: state, octet count and the layout of the frame in flight.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_mode = mode_ff;
    case (state_ff)
      SLM_TX_IDLE: begin
        nxt_cnt = 4'h0;
      end
      SLM_TX_SEND: begin
        nxt_cnt = cnt_ff + 4'h1;
        if (last_oct) begin
          nxt_state = SLM_TX_IDLE;
        end
      end
      default: begin
        nxt_state = SLM_TX_IDLE;
        nxt_cnt = 4'h0;
      end
    endcase
    // A frame taken in the last octet cycle follows with no gap.
    if (take) begin
      nxt_cnt = 4'h0;
      nxt_mode = link_layout_select;
      nxt_state = SLM_TX_SEND;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SLM_TX_IDLE;
      cnt_ff <= 4'h0;
      mode_ff <= `SLM_MODE_0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      mode_ff <= nxt_mode;
    end
  end

  // Lane shifters: octet 0 sits at the top of each lane and leaves first.
  always_comb begin
    nxt_shift = shift_ff;
    if (in_frame) begin
      nxt_shift = shift_up(shift_ff);
    end
    if (take) begin
      nxt_shift = pack_frame(link_layout_select, frm_samples);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= '0;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // Lane power follows the live select one cycle late; a refused select powers every lane down.
  always_comb begin
    nxt_lane_on = slm_pkg::lane_mask(link_layout_select);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_on_ff <= 8'h00;
    end else begin
      lane_on_ff <= nxt_lane_on;
    end
  end

  // Handshake flags decode the control registers; lane data comes straight from the shifters.
  always_comb begin
    for (int l = 0; l < 8; l++) begin
      link.lane[l] = shift_ff[l][63:56];
    end
    link.lane_on = lane_on_ff;
    link.oct_valid = in_frame;
    link.frame_start = first_oct;
  end

endmodule // slm_tx

/* inc/slm_cfg.svh */
`ifndef SLM_CFG_SVH
`define SLM_CFG_SVH

// Layout select codes.
`define SLM_MODE_0 4'h0
`define SLM_MODE_1 4'h1
`define SLM_MODE_2 4'h2
`define SLM_MODE_3 4'h3
`define SLM_MODE_4 4'h4
`define SLM_MODE_5 4'h5
`define SLM_MODE_6 4'h6
`define SLM_MODE_7 4'h7

// Octets in one lane frame for each layout.
`define SLM_OCT_M0 4'h8
`define SLM_OCT_M1 4'h2
`define SLM_OCT_M2 4'h1
`define SLM_OCT_M3 4'h5
`define SLM_OCT_M4 4'h2
`define SLM_OCT_M5 4'h2
`define SLM_OCT_M6 4'h2
`define SLM_OCT_M7 4'h1

// Lanes in use for each layout, lowest indices first.
`define SLM_LANES_M0 8'hFF
`define SLM_LANES_M1 8'h3F
`define SLM_LANES_M2 8'h0F
`define SLM_LANES_M3 8'h0F
`define SLM_LANES_M4 8'h07
`define SLM_LANES_M5 8'h03
`define SLM_LANES_M6 8'h3F
`define SLM_LANES_M7 8'h0F

// Frame geometry.
`define SLM_NUM_LANES 8
`define SLM_NUM_CH 4
`define SLM_NUM_SMP 10
`define SLM_SMP_W 12
`define SLM_FRM_W 64

`endif

/* inc/slm_link_if.sv */
interface slm_link_if;
  slm_pkg::slm_octs_t lane;
  logic [7:0] lane_on;
  logic oct_valid;
  logic frame_start;

  modport tx (
    output lane,
    output lane_on,
    output oct_valid,
    output frame_start
  );

  modport rx (
    input lane,
    input lane_on,
    input oct_valid,
    input frame_start
  );
endinterface

/* inc/slm_pkg.sv */
`include "slm_cfg.svh"

package slm_pkg;

  typedef enum logic [3:0] {
    SLM_M0 = `SLM_MODE_0,
    SLM_M1 = `SLM_MODE_1,
    SLM_M2 = `SLM_MODE_2,
    SLM_M3 = `SLM_MODE_3,
    SLM_M4 = `SLM_MODE_4,
    SLM_M5 = `SLM_MODE_5,
    SLM_M6 = `SLM_MODE_6,
    SLM_M7 = `SLM_MODE_7
  } slm_mode_t;

  // Lane frames are left justified: octet 0 sits in bits 63:56.
  typedef logic [`SLM_NUM_LANES-1:0][`SLM_FRM_W-1:0] slm_lanes_t;
  // Channel A is index 0; sample n of a channel is index n, right justified.
  typedef logic [`SLM_NUM_CH-1:0][`SLM_NUM_SMP-1:0][`SLM_SMP_W-1:0] slm_chans_t;
  typedef logic [`SLM_NUM_LANES-1:0][7:0] slm_octs_t;

  function automatic logic [3:0] oct_per_frame(input logic [3:0] mode);
    case (mode)
      `SLM_MODE_0: oct_per_frame = `SLM_OCT_M0;
      `SLM_MODE_1: oct_per_frame = `SLM_OCT_M1;
      `SLM_MODE_2: oct_per_frame = `SLM_OCT_M2;
      `SLM_MODE_3: oct_per_frame = `SLM_OCT_M3;
      `SLM_MODE_4: oct_per_frame = `SLM_OCT_M4;
      `SLM_MODE_5: oct_per_frame = `SLM_OCT_M5;
      `SLM_MODE_6: oct_per_frame = `SLM_OCT_M6;
      `SLM_MODE_7: oct_per_frame = `SLM_OCT_M7;
      default: oct_per_frame = 4'h1;
    endcase
  endfunction

  function automatic logic [7:0] lane_mask(input logic [3:0] mode);
    case (mode)
      `SLM_MODE_0: lane_mask = `SLM_LANES_M0;
      `SLM_MODE_1: lane_mask = `SLM_LANES_M1;
      `SLM_MODE_2: lane_mask = `SLM_LANES_M2;
      `SLM_MODE_3: lane_mask = `SLM_LANES_M3;
      `SLM_MODE_4: lane_mask = `SLM_LANES_M4;
      `SLM_MODE_5: lane_mask = `SLM_LANES_M5;
      `SLM_MODE_6: lane_mask = `SLM_LANES_M6;
      `SLM_MODE_7: lane_mask = `SLM_LANES_M7;
      default: lane_mask = 8'h00;
    endcase
  endfunction

  function automatic logic mode_ok(input logic [3:0] mode);
    mode_ok = (lane_mask(mode) != 8'h00);
  endfunction

endpackage

/* verif/slm_link_asserts.sv */
module slm_link_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire slm_pkg::slm_octs_t lane,
  input wire logic [7:0] lane_on,
  input wire logic oct_valid,
  input wire logic frame_start
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] off_or;
  logic [3:0] tail_or;
  // Folded views keep each lane-wide property to one line.
  always_comb begin
    off_or = 8'h00;
    tail_or = 4'h0;
    for (int i = 0; i < 8; i++) begin
      off_or = off_or | (lane[i] & {8{~lane_on[i]}});
      tail_or = tail_or | lane[i][3:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_idle_lanes_zero: assert property (!oct_valid |-> lane == '0)
    else $error("lane data while idle");
  chk_off_lanes_zero: assert property (off_or == 8'h00)
    else $error("data on a powered down lane");
  chk_lanes_lowest: assert property ((lane_on & (lane_on + 8'h01)) == 8'h00)
    else $error("powered lanes not lowest first");
  chk_start_in_frame: assert property (frame_start |-> oct_valid)
    else $error("frame start without octet");
  chk_start_first_octet: assert property ($rose(oct_valid) |-> frame_start)
    else $error("frame began without start");
  chk_mode0_eight_octets: assert property (frame_start && lane_on == 8'hFF |=>
    (oct_valid && !frame_start) [*7] ##1 (!oct_valid || frame_start))
    else $error("eight lane frame has wrong length");
  chk_two_octet_frames: assert property (frame_start &&
    (lane_on == 8'h3F || lane_on == 8'h07 || lane_on == 8'h03) |=>
    (oct_valid && !frame_start) ##1 (!oct_valid || frame_start))
    else $error("two octet frame has wrong length");
  chk_mode0_tail_zero: assert property (frame_start && lane_on == 8'hFF |-> ##7 tail_or == 4'h0)
    else $error("tail nibble not zero");
endmodule // slm_link_asserts

/* verif/test_adc_sample_lane_mapper.sv */
`define SLM_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); miscompares++; end end

module test_adc_sample_lane_mapper;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] sel = 4'h0;
  logic frm_valid = 1'b0;
  logic frm_ready, out_valid, tail_err, lane_err;
  slm_pkg::slm_chans_t smp = '0;
  slm_pkg::slm_chans_t out_smp;
  slm_pkg::slm_lanes_t got, exp;
  int miscompares = 0;
  int samples_checked = 0;
  slm_link_if link ();
  slm_tx slm_tx_inst (.clk(clk), .rst_n(rst_n), .link_layout_select(sel), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .frm_samples(smp), .link(link.tx));
  slm_rx slm_rx_inst (.clk(clk), .rst_n(rst_n), .link_layout_select(sel), .link(link.rx),
    .out_valid(out_valid), .out_samples(out_smp), .tail_err(tail_err), .lane_err(lane_err));
  slm_link_asserts slm_link_asserts_inst (.clk(clk), .rst_n(rst_n), .lane(link.lane),
    .lane_on(link.lane_on), .oct_valid(link.oct_valid), .frame_start(link.frame_start));
  always #20 clk = ~clk;

  task give_verdict;
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Unused sample slots stay zero, so the unpacked result must equal the input.
  task automatic fill(input int ns, input int w);
    logic [11:0] v;
    smp = '0;
    exp = '0;
    for (int c = 0; c < 4; c++) begin
      for (int n = 0; n < ns; n++) begin
        v = 12'h5A3 ^ (12'(c) * 12'h0F1) ^ (12'(n) * 12'h137);
        smp[c][n] = v & ~(12'hFFF << w);
      end
    end
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    while (frm_ready !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (frm_ready !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
  endtask

  // Select changes only while idle, since the receiver follows it live.
  task automatic send(input logic [3:0] m, input int f, input logic [7:0] mask);
    sel = m;
    repeat (2) @(negedge clk);
    frm_valid = 1'b1;
    wait_ready();
    @(negedge clk);
    frm_valid = 1'b0;
    got = '0;
    for (int k = 0; k < f; k++) begin
      `SLM_CHK("frame_start", k == 0, link.frame_start)
      `SLM_CHK("oct_valid in frame", 1'b1, link.oct_valid)
      `SLM_CHK("frm_ready in frame", k == f - 1, frm_ready)
      for (int l = 0; l < 8; l++) got[l][63 - 8 * k -: 8] = link.lane[l];
      @(negedge clk);
    end
    `SLM_CHK("lane_on", mask, link.lane_on)
    `SLM_CHK("oct_valid", 1'b0, link.oct_valid)
    `SLM_CHK("out_valid", 1'b1, out_valid)
    `SLM_CHK("out_samples", smp, out_smp)
    `SLM_CHK("tail_err", 1'b0, tail_err)
    `SLM_CHK("lane_err", 1'b0, lane_err)
  endtask

  task automatic scen_m0;
    int c, p;
    fill(10, 12);
    for (int l = 0; l < 8; l++) begin
      c = l / 2;
      p = l % 2;
      exp[l] = {smp[c][p], smp[c][p + 2], smp[c][p + 4], smp[c][p + 6], smp[c][p + 8], 4'h0};
    end
    send(4'h0, 8, 8'hFF);
    `SLM_CHK("mode0 lanes", exp, got)
  endtask

  task automatic scen_m16(input logic [3:0] m);
    logic [95:0] b;
    fill(2, 12);
    b = {smp[0][0], smp[0][1], smp[1][0], smp[1][1], smp[2][0], smp[2][1], smp[3][0], smp[3][1]};
    for (int l = 0; l < 6; l++) exp[l] = {b[95 - 16 * l -: 16], 48'h0};
    send(m, 2, 8'h3F);
    `SLM_CHK("six lane frames", exp, got)
  endtask

  task automatic scen_m27(input logic [3:0] m);
    fill(1, 8);
    for (int c = 0; c < 4; c++) exp[c] = {smp[c][0][7:0], 56'h0};
    send(m, 1, 8'h0F);
    `SLM_CHK("octet lanes", exp, got)
  endtask

  task automatic scen_m3;
    fill(4, 10);
    for (int c = 0; c < 4; c++) exp[c] = {smp[c][0][9:0], smp[c][1][9:0], smp[c][2][9:0], smp[c][3][9:0], 24'h0};
    send(4'h3, 5, 8'h0F);
    `SLM_CHK("mode3 lanes", exp, got)
  endtask

  task automatic scen_m4;
    logic [47:0] b;
    fill(1, 12);
    b = {smp[0][0], smp[1][0], smp[2][0], smp[3][0]};
    for (int l = 0; l < 3; l++) exp[l] = {b[47 - 16 * l -: 16], 48'h0};
    send(4'h4, 2, 8'h07);
    `SLM_CHK("mode4 lanes", exp, got)
  endtask

  task automatic scen_m5;
    fill(1, 8);
    exp[0] = {smp[0][0][7:0], smp[1][0][7:0], 48'h0};
    exp[1] = {smp[2][0][7:0], smp[3][0][7:0], 48'h0};
    send(4'h5, 2, 8'h03);
    `SLM_CHK("mode5 lanes", exp, got)
  endtask

  // Holding valid takes a second frame in the last octet cycle of the first.
  task automatic scen_b2b;
    fill(1, 8);
    sel = 4'h2;
    repeat (2) @(negedge clk);
    frm_valid = 1'b1;
    wait_ready();
    @(negedge clk);
    `SLM_CHK("first start", 1'b1, link.frame_start)
    @(negedge clk);
    `SLM_CHK("second start", 1'b1, link.frame_start)
    frm_valid = 1'b0;
    @(negedge clk);
    `SLM_CHK("idle after pair", 1'b0, link.oct_valid)
    `SLM_CHK("pair out_valid", 1'b1, out_valid)
    `SLM_CHK("pair samples", smp, out_smp)
  endtask

  task automatic scen_bad;
    sel = 4'h8;
    @(negedge clk);
    `SLM_CHK("lane_err on change", 1'b1, lane_err)
    @(negedge clk);
    `SLM_CHK("lane_err settled", 1'b0, lane_err)
    `SLM_CHK("ready unsupported", 1'b0, frm_ready)
    `SLM_CHK("lanes off", 8'h00, link.lane_on)
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    scen_m0;
    scen_m16(4'h1);
    scen_m16(4'h6);
    scen_m27(4'h2);
    scen_m27(4'h7);
    scen_m3;
    scen_m4;
    scen_m5;
    scen_b2b;
    scen_bad;
    scen_m0;
    give_verdict();
  end
endmodule // test_adc_sample_lane_mapper
